// ===== verilog/pmon_pkg.sv
package pmon_pkg;

   // Conversion code layout
   localparam int CODE_W = 12;
   localparam int HI_LSB = 4;

   // Command byte bits
   localparam int CMD_V_CONT    = 0;
   localparam int CMD_V_ONCE    = 1;
   localparam int CMD_I_CONT    = 2;
   localparam int CMD_I_ONCE    = 3;
   localparam int CMD_DIV_SEL   = 4;
   localparam int CMD_STATUS_RD = 6;
   localparam int CMD_EXT       = 7;

   // Extended register selectors
   localparam logic [1:0] EXT_ALERT_EN = 2'h1;
   localparam logic [1:0] EXT_THRESH   = 2'h2;
   localparam logic [1:0] EXT_CONTROL  = 2'h3;

   // Alert enable bits
   localparam int AEN_OC1   = 0;
   localparam int AEN_OC4   = 1;
   localparam int AEN_HS    = 2;
   localparam int AEN_OFF   = 3;
   localparam int AEN_CLEAR = 4;

   // Control bits
   localparam int CTRL_SOFT_OFF = 0;

   // Status byte bits
   localparam int STS_OC_LIVE   = 0;
   localparam int STS_ADC_ALERT = 1;
   localparam int STS_HS_OC     = 2;
   localparam int STS_SWAP_FAIL = 3;
   localparam int STS_OFF       = 4;
   localparam int STS_OFF_ALERT = 5;

   // Reset values
   localparam logic [7:0] THRESH_RESET  = 8'hff;
   localparam logic [7:0] CONTROL_RESET = 8'h00;
   localparam logic [7:0] AEN_RESET     = 8'h04;
   localparam logic [7:0] CMD_RESET     = 8'h00;
   localparam logic [7:0] IDLE_BYTE     = 8'hff;

   // Bus address, arbitrary default
   localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h2a;

   // Serial framing
   localparam logic [3:0] BITS_IN_BYTE = 4'h8;
   localparam logic [3:0] LAST_OUT_BIT = 4'h7;

   typedef enum logic [6:0] {
      ST_IDLE     = 7'h01,
      ST_ADDR     = 7'h02,
      ST_ADDR_ACK = 7'h04,
      ST_WR_BYTE  = 7'h08,
      ST_WR_ACK   = 7'h10,
      ST_RD_BYTE  = 7'h20,
      ST_RD_ACK   = 7'h40
   } link_state_t;

   typedef enum logic [3:0] {
      RM_BOTH   = 4'h1,
      RM_VOLT   = 4'h2,
      RM_CURR   = 4'h4,
      RM_STATUS = 4'h8
   } read_mode_t;

endpackage

// ===== verilog/pmon_readback_format.sv
`timescale 1ns/10ps
module pmon_readback_format (
   input  wire pmon_pkg::read_mode_t     mode,      // Readback format
   input  wire logic [1:0]               byte_idx,  // Byte within read
   input  wire logic [pmon_pkg::CODE_W-1:0] volt_code, // Voltage result
   input  wire logic [pmon_pkg::CODE_W-1:0] curr_code, // Current result
   input  wire logic [7:0]               status_byte, // Status byte
   output logic [7:0]                    data_byte  // Byte to send
);
   localparam int H = pmon_pkg::HI_LSB;
   localparam int T = pmon_pkg::CODE_W - 1;

   always_comb begin
      data_byte = pmon_pkg::IDLE_BYTE;
      case (mode)
         pmon_pkg::RM_STATUS: begin
            data_byte = status_byte;
         end
         pmon_pkg::RM_VOLT: begin
            if (byte_idx == 2'h0) begin
               data_byte = volt_code[T:H];
            end else if (byte_idx == 2'h1) begin
               data_byte = {volt_code[H-1:0], 4'h0};            // [RULE6]
            end
         end
         pmon_pkg::RM_CURR: begin
            if (byte_idx == 2'h0) begin
               data_byte = curr_code[T:H];
            end else if (byte_idx == 2'h1) begin
               data_byte = {curr_code[H-1:0], 4'h0};            // [RULE7]
            end
         end
         default: begin
            if (byte_idx == 2'h0) begin
               data_byte = volt_code[T:H];                      // [RULE5]
            end else if (byte_idx == 2'h1) begin
               data_byte = curr_code[T:H];                      // [RULE5]
            end else if (byte_idx == 2'h2) begin
               data_byte = {volt_code[H-1:0], curr_code[H-1:0]}; // [RULE5]
            end
         end
      endcase
   end
endmodule

// ===== verilog/power_monitor_i2c_readback.sv
// Functional notes
// RULE1: 8-bit current alert threshold register, resets to all ones.
// RULE2: Threshold compared with upper eight bits of the 12-bit current code.
// RULE3: Control bit 0 forces hot swap off like deasserted enable; resets 0.
// RULE4: Read format is both, voltage only or current only per last command.
// RULE5: Both: V[11:4], I[11:4], then V[3:0] high nibble, I[3:0] low.
// RULE6: Voltage only: V[11:4], then V[3:0] high nibble, low nibble zero.
// RULE7: Current only: I[11:4], then I[3:0] high nibble, low nibble zero.
// RULE8: Three-byte read: address with read bit, slave acks, master acks two.
// RULE9: Master takes only two bytes for single-channel reads.
// RULE10: Voltage code is 12-bit unsigned, full scale over 4096 codes.
// RULE11: Current code is 12-bit unsigned, 105.84 mV over 4096 codes.
// RULE12: Status read: address with read bit, slave acks, one status byte.
// RULE13: Status bits 1, 3, 5 latch; cleared only by alert enable bit 4.
// RULE14: Status bit 0 is live overcurrent over the last three conversions.
// RULE15: Status-select command bit makes every read return the status byte.
// RULE16: Extended write, register byte MSB set, two LSBs select register.
// RULE17: Status bit 4 is high while enable is low or soft power-off is set.
// RULE18: Status bit 1 latches on an ADC-based overcurrent alert.
// RULE19: Overcurrent flagged only when upper current bits exceed threshold.
`timescale 1ns/10ps
module power_monitor_i2c_readback #(
   parameter logic [6:0] DEV_ADDR = pmon_pkg::DEV_ADDR_DEFAULT
) (
   input  wire logic        CORE_CLK,       // 50 MHz core clock
   input  wire logic        RESET_N,        // Async reset, active low
   input  wire logic        SCL,            // Bus clock pin
   input  wire logic        SDA_IN,         // Bus data pin level
   output logic             SDA_OUT,        // Bus data drive value
   output logic             SDA_OE_N,       // Low while pulling data low
   input  wire logic        POWER_ENABLE,   // Power enable pin
   input  wire logic        V_DONE,         // Voltage conversion done
   input  wire logic [11:0] V_CODE,         // Voltage result
   input  wire logic        I_DONE,         // Current conversion done
   input  wire logic [11:0] I_CODE,         // Current result
   input  wire logic        HS_FAIL,        // Hot swap failure pulse
   input  wire logic        HS_OC,          // Analog overcurrent off level
   output logic             HOT_SWAP_OFF,   // Hot swap forced off
   output logic             VOLT_CONT,      // Continuous voltage conversion
   output logic             VOLT_ONCE,      // Single voltage request pulse
   output logic             CURR_CONT,      // Continuous current conversion
   output logic             CURR_ONCE,      // Single current request pulse
   output logic             VOLTAGE_DIVIDER_SELECT, // Voltage range
   input  wire logic        ALERT_OUTPUT_N_IN,  // Alert pin level
   output logic             ALERT_OUTPUT_N_OUT, // Alert drive value
   output logic             ALERT_OUTPUT_N_OE_N // Low while alert asserted
);
   typedef struct packed {
      pmon_pkg::link_state_t state;
      logic [3:0]  cnt;
      logic [7:0]  sr;
      logic [7:0]  out;
      logic        rw;
      logic        first;
      logic        ext;
      logic [1:0]  ext_sel;
      logic [1:0]  idx;
      logic        mack;
      logic        sda_drv;
      logic [7:0]  cmd;
      logic [7:0]  thresh;
      logic [7:0]  ctrl;
      logic [7:0]  aen;
      logic [11:0] v_data;
      logic [11:0] i_data;
      logic [3:0]  oc_hist;
      logic        adc_alert;
      logic        swap_fail;
      logic        off_alert;
      logic        off_prev;
      logic        v_pend;
      logic        i_pend;
      logic        v_once_p;
      logic        i_once_p;
      logic [1:0]  scl_s;
      logic [1:0]  sda_s;
      logic [1:0]  on_s;
      logic        scl_d;
      logic        sda_d;
   } core_t;

   core_t                r_ff;
   core_t                nxt_r;
   logic                 scl_rise;
   logic                 scl_fall;
   logic                 bus_start;
   logic                 bus_stop;
   logic                 exceed;
   logic                 oc_live;
   logic                 off_status;
   logic                 adc_set;
   logic                 hs_set;
   logic                 off_set;
   logic                 clr_pulse;
   logic [7:0]           status;
   logic [7:0]           fmt_byte;
   pmon_pkg::read_mode_t mode;

   assign scl_rise  = r_ff.scl_s[1] & ~r_ff.scl_d;
   assign scl_fall  = ~r_ff.scl_s[1] & r_ff.scl_d;
   assign bus_start = r_ff.scl_s[1] & r_ff.scl_d & r_ff.sda_d & ~r_ff.sda_s[1];
   assign bus_stop  = r_ff.scl_s[1] & r_ff.scl_d & ~r_ff.sda_d & r_ff.sda_s[1];

   assign exceed  = I_CODE[11:pmon_pkg::HI_LSB] > r_ff.thresh; // [RULE2] [RULE19]
   assign oc_live = &r_ff.oc_hist[2:0];                        // [RULE14]
   assign off_status = ~r_ff.on_s[1]
                     | r_ff.ctrl[pmon_pkg::CTRL_SOFT_OFF];     // [RULE3] [RULE17]
   assign adc_set = I_DONE & exceed
                  & (r_ff.aen[pmon_pkg::AEN_OC1]
                  | (r_ff.aen[pmon_pkg::AEN_OC4] & (&r_ff.oc_hist[2:0])));
   assign hs_set  = HS_FAIL & r_ff.aen[pmon_pkg::AEN_HS];
   assign off_set = off_status & ~r_ff.off_prev & r_ff.aen[pmon_pkg::AEN_OFF];

   always_comb begin
      status = 8'h00;
      status[pmon_pkg::STS_OC_LIVE]   = oc_live;
      status[pmon_pkg::STS_ADC_ALERT] = r_ff.adc_alert;
      status[pmon_pkg::STS_HS_OC]     = HS_OC;
      status[pmon_pkg::STS_SWAP_FAIL] = r_ff.swap_fail;
      status[pmon_pkg::STS_OFF]       = off_status;
      status[pmon_pkg::STS_OFF_ALERT] = r_ff.off_alert;
   end

   // Format follows the last command byte
   always_comb begin
      if (r_ff.cmd[pmon_pkg::CMD_STATUS_RD]) begin
         mode = pmon_pkg::RM_STATUS;                           // [RULE15]
      end else if ((r_ff.cmd[pmon_pkg::CMD_V_CONT] | r_ff.cmd[pmon_pkg::CMD_V_ONCE])
                 & ~(r_ff.cmd[pmon_pkg::CMD_I_CONT] | r_ff.cmd[pmon_pkg::CMD_I_ONCE])) begin
         mode = pmon_pkg::RM_VOLT;                             // [RULE4]
      end else if (~(r_ff.cmd[pmon_pkg::CMD_V_CONT] | r_ff.cmd[pmon_pkg::CMD_V_ONCE])
                 & (r_ff.cmd[pmon_pkg::CMD_I_CONT] | r_ff.cmd[pmon_pkg::CMD_I_ONCE])) begin
         mode = pmon_pkg::RM_CURR;                             // [RULE4]
      end else begin
         mode = pmon_pkg::RM_BOTH;
      end
   end

   pmon_readback_format u_format (
      .mode        (mode),
      .byte_idx    (r_ff.idx),
      .volt_code   (r_ff.v_data),
      .curr_code   (r_ff.i_data),
      .status_byte (status),
      .data_byte   (fmt_byte)
   );

   always_comb begin
      nxt_r = r_ff;
      clr_pulse = 1'b0;
      nxt_r.scl_s = {r_ff.scl_s[0], SCL};
      nxt_r.sda_s = {r_ff.sda_s[0], SDA_IN};
      nxt_r.on_s  = {r_ff.on_s[0], POWER_ENABLE};
      nxt_r.scl_d = r_ff.scl_s[1];
      nxt_r.sda_d = r_ff.sda_s[1];
      nxt_r.off_prev = off_status;
      nxt_r.v_once_p = 1'b0;
      nxt_r.i_once_p = 1'b0;
      if (V_DONE) begin
         nxt_r.v_data = V_CODE;                                // [RULE10]
         nxt_r.v_pend = 1'b0;
      end
      if (I_DONE) begin
         nxt_r.i_data  = I_CODE;                               // [RULE11]
         nxt_r.i_pend  = 1'b0;
         nxt_r.oc_hist = {r_ff.oc_hist[2:0], exceed};          // [RULE14]
      end
      if (bus_start) begin
         nxt_r.state   = pmon_pkg::ST_ADDR;
         nxt_r.cnt     = 4'h0;
         nxt_r.sda_drv = 1'b0;
      end else if (bus_stop) begin
         nxt_r.state   = pmon_pkg::ST_IDLE;
         nxt_r.sda_drv = 1'b0;
      end else begin
         case (r_ff.state)
            pmon_pkg::ST_ADDR: begin
               if (scl_rise) begin
                  nxt_r.sr  = {r_ff.sr[6:0], r_ff.sda_s[1]};
                  nxt_r.cnt = r_ff.cnt + 4'h1;
               end else if (scl_fall && r_ff.cnt == pmon_pkg::BITS_IN_BYTE) begin
                  // Reads refused while a single conversion is pending
                  if (r_ff.sr[7:1] == DEV_ADDR
                      && !(r_ff.sr[0] && (r_ff.v_pend || r_ff.i_pend))) begin
                     nxt_r.rw      = r_ff.sr[0];
                     nxt_r.sda_drv = 1'b1;                     // [RULE8] [RULE12]
                     nxt_r.first   = 1'b1;
                     nxt_r.idx     = 2'h0;
                     nxt_r.state   = pmon_pkg::ST_ADDR_ACK;
                  end else begin
                     nxt_r.state = pmon_pkg::ST_IDLE;
                  end
               end
            end
            pmon_pkg::ST_ADDR_ACK: begin
               if (scl_fall) begin
                  nxt_r.cnt = 4'h0;
                  if (r_ff.rw) begin
                     nxt_r.out     = fmt_byte;
                     nxt_r.sda_drv = ~fmt_byte[7];
                     nxt_r.idx     = 2'h1;
                     nxt_r.state   = pmon_pkg::ST_RD_BYTE;
                  end else begin
                     nxt_r.sda_drv = 1'b0;
                     nxt_r.state   = pmon_pkg::ST_WR_BYTE;
                  end
               end
            end
            pmon_pkg::ST_RD_BYTE: begin
               if (scl_fall) begin
                  if (r_ff.cnt == pmon_pkg::LAST_OUT_BIT) begin
                     nxt_r.sda_drv = 1'b0;
                     nxt_r.state   = pmon_pkg::ST_RD_ACK;
                  end else begin
                     nxt_r.out     = {r_ff.out[6:0], 1'b0};
                     nxt_r.sda_drv = ~r_ff.out[6];
                     nxt_r.cnt     = r_ff.cnt + 4'h1;
                  end
               end
            end
            pmon_pkg::ST_RD_ACK: begin
               if (scl_rise) begin
                  nxt_r.mack = ~r_ff.sda_s[1];
               end else if (scl_fall) begin
                  // A status read is one byte, acknowledged or not
                  if (r_ff.mack
                      && mode != pmon_pkg::RM_STATUS) begin    // [RULE8]
                     nxt_r.out     = fmt_byte;
                     nxt_r.sda_drv = ~fmt_byte[7];
                     nxt_r.idx     = r_ff.idx + 2'h1;
                     nxt_r.cnt     = 4'h0;
                     nxt_r.state   = pmon_pkg::ST_RD_BYTE;
                  end else begin
                     nxt_r.state = pmon_pkg::ST_IDLE;          // [RULE12]
                  end
               end
            end
            pmon_pkg::ST_WR_BYTE: begin
               if (scl_rise) begin
                  nxt_r.sr  = {r_ff.sr[6:0], r_ff.sda_s[1]};
                  nxt_r.cnt = r_ff.cnt + 4'h1;
               end else if (scl_fall && r_ff.cnt == pmon_pkg::BITS_IN_BYTE) begin
                  nxt_r.sda_drv = 1'b1;
                  nxt_r.state   = pmon_pkg::ST_WR_ACK;
                  nxt_r.first   = 1'b0;
                  if (r_ff.first) begin
                     nxt_r.ext = r_ff.sr[pmon_pkg::CMD_EXT];    // [RULE16]
                     if (r_ff.sr[pmon_pkg::CMD_EXT]) begin
                        nxt_r.ext_sel = r_ff.sr[1:0];          // [RULE16]
                     end else begin
                        nxt_r.cmd      = r_ff.sr;
                        nxt_r.v_once_p = r_ff.sr[pmon_pkg::CMD_V_ONCE];
                        nxt_r.i_once_p = r_ff.sr[pmon_pkg::CMD_I_ONCE];
                        nxt_r.v_pend   = r_ff.sr[pmon_pkg::CMD_V_ONCE];
                        nxt_r.i_pend   = r_ff.sr[pmon_pkg::CMD_I_ONCE];
                     end
                  end else if (r_ff.ext) begin
                     nxt_r.ext = 1'b0;
                     if (r_ff.ext_sel == pmon_pkg::EXT_ALERT_EN) begin
                        nxt_r.aen = r_ff.sr;
                        nxt_r.aen[pmon_pkg::AEN_CLEAR] = 1'b0;
                        clr_pulse = r_ff.sr[pmon_pkg::AEN_CLEAR]; // [RULE13]
                     end else if (r_ff.ext_sel == pmon_pkg::EXT_THRESH) begin
                        nxt_r.thresh = r_ff.sr;                // [RULE1] [RULE16]
                     end else if (r_ff.ext_sel == pmon_pkg::EXT_CONTROL) begin
                        nxt_r.ctrl = r_ff.sr;                  // [RULE3] [RULE16]
                     end
                  end
               end
            end
            pmon_pkg::ST_WR_ACK: begin
               if (scl_fall) begin
                  nxt_r.sda_drv = 1'b0;
                  nxt_r.cnt     = 4'h0;
                  nxt_r.state   = pmon_pkg::ST_WR_BYTE;
               end
            end
            default: begin
               nxt_r.state = pmon_pkg::ST_IDLE;
            end
         endcase
      end
      // Latched alerts: a new event wins over a clear
      if (clr_pulse) begin
         nxt_r.adc_alert = 1'b0;                               // [RULE13]
         nxt_r.swap_fail = 1'b0;
         nxt_r.off_alert = 1'b0;
      end
      if (adc_set) begin
         nxt_r.adc_alert = 1'b1;                               // [RULE18]
      end
      if (hs_set) begin
         nxt_r.swap_fail = 1'b1;
      end
      if (off_set) begin
         nxt_r.off_alert = 1'b1;
      end
   end

   always_ff @(posedge CORE_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         r_ff        <= '0;
         r_ff.state  <= pmon_pkg::ST_IDLE;
         r_ff.cmd    <= pmon_pkg::CMD_RESET;
         r_ff.thresh <= pmon_pkg::THRESH_RESET;                // [RULE1]
         r_ff.ctrl   <= pmon_pkg::CONTROL_RESET;               // [RULE3]
         r_ff.aen    <= pmon_pkg::AEN_RESET;
         r_ff.scl_s  <= 2'h3;
         r_ff.sda_s  <= 2'h3;
         r_ff.scl_d  <= 1'b1;
         r_ff.sda_d  <= 1'b1;
      end else begin
         r_ff <= nxt_r;
      end
   end

   assign SDA_OUT             = 1'b0;
   assign SDA_OE_N            = ~r_ff.sda_drv;
   assign HOT_SWAP_OFF        = off_status;                    // [RULE3]
   assign VOLT_CONT           = r_ff.cmd[pmon_pkg::CMD_V_CONT];
   assign CURR_CONT           = r_ff.cmd[pmon_pkg::CMD_I_CONT];
   assign VOLT_ONCE           = r_ff.v_once_p;
   assign CURR_ONCE           = r_ff.i_once_p;
   assign VOLTAGE_DIVIDER_SELECT = r_ff.cmd[pmon_pkg::CMD_DIV_SEL];
   assign ALERT_OUTPUT_N_OUT  = 1'b0;
   assign ALERT_OUTPUT_N_OE_N = ~(r_ff.adc_alert | r_ff.swap_fail
                                | r_ff.off_alert);

   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (!RESET_N);

   chk_thresh_write: assert property ( // [RULE1] [RULE16]
      !$stable(r_ff.thresh) |-> $past(r_ff.state == pmon_pkg::ST_WR_BYTE
         && r_ff.ext && r_ff.ext_sel == pmon_pkg::EXT_THRESH))
      else $error("threshold changed outside extended write");
   chk_oc_compare: assert property ( // [RULE2] [RULE19]
      I_DONE |=> r_ff.oc_hist[0] ==
         ($past(I_CODE[11:4]) > $past(r_ff.thresh)))
      else $error("overcurrent compare wrong");
   chk_soft_off: assert property ( // [RULE3]
      r_ff.ctrl[pmon_pkg::CTRL_SOFT_OFF] |-> HOT_SWAP_OFF
         && status[pmon_pkg::STS_OFF])
      else $error("soft power-off not effective");
   chk_enable_off: assert property ( // [RULE17]
      $fell(POWER_ENABLE) ##2 !POWER_ENABLE[*2] |-> status[pmon_pkg::STS_OFF])
      else $error("off status missing after enable low");
   chk_live_rise: assert property ( // [RULE14]
      $rose(status[pmon_pkg::STS_OC_LIVE]) |-> $past(I_DONE && exceed))
      else $error("live overcurrent without conversion");
   chk_latch_hold: assert property ( // [RULE13]
      r_ff.adc_alert && !clr_pulse |=> r_ff.adc_alert)
      else $error("latched alert dropped without clear");
   chk_clear_acts: assert property ( // [RULE13]
      clr_pulse && !hs_set |=> !r_ff.swap_fail)
      else $error("clear did not clear alert");
   chk_adc_latch: assert property ( // [RULE18]
      I_DONE && exceed && r_ff.aen[pmon_pkg::AEN_OC1] |=> r_ff.adc_alert
         && !ALERT_OUTPUT_N_OE_N)
      else $error("adc alert not latched");
   chk_addr_ack: assert property ( // [RULE8] [RULE12]
      r_ff.state == pmon_pkg::ST_ADDR && scl_fall && !bus_start
         && !bus_stop && r_ff.cnt == 4'h8 && r_ff.sr[7:1] == DEV_ADDR
         && !r_ff.v_pend && !r_ff.i_pend |=> !SDA_OE_N)
      else $error("address not acknowledged");
   chk_third_byte: assert property ( // [RULE5]
      r_ff.state == pmon_pkg::ST_RD_ACK && scl_fall && !bus_start
         && !bus_stop && r_ff.mack && r_ff.idx == 2'h2
         && mode == pmon_pkg::RM_BOTH
      |=> r_ff.out == {$past(r_ff.v_data[3:0]), $past(r_ff.i_data[3:0])})
      else $error("combined third byte wrong");
   chk_volt_second: assert property ( // [RULE6]
      r_ff.state == pmon_pkg::ST_RD_ACK && scl_fall && !bus_start
         && !bus_stop && r_ff.mack && r_ff.idx == 2'h1
         && mode == pmon_pkg::RM_VOLT
      |=> r_ff.out == {$past(r_ff.v_data[3:0]), 4'h0})
      else $error("voltage second byte wrong");
   chk_curr_second: assert property ( // [RULE7]
      r_ff.state == pmon_pkg::ST_RD_ACK && scl_fall && !bus_start
         && !bus_stop && r_ff.mack && r_ff.idx == 2'h1
         && mode == pmon_pkg::RM_CURR
      |=> r_ff.out == {$past(r_ff.i_data[3:0]), 4'h0})
      else $error("current second byte wrong");
   chk_status_sel: assert property ( // [RULE15] [RULE4]
      r_ff.state == pmon_pkg::ST_ADDR_ACK && scl_fall && !bus_start
         && !bus_stop && r_ff.rw && r_ff.cmd[pmon_pkg::CMD_STATUS_RD]
      |=> r_ff.out == $past(status))
      else $error("status byte not selected");
   chk_code_take: assert property ( // [RULE10] [RULE11]
      V_DONE && I_DONE |=> r_ff.v_data == $past(V_CODE)
         && r_ff.i_data == $past(I_CODE))
      else $error("conversion code not captured");

   cov_three_byte: cover property (
      r_ff.state == pmon_pkg::ST_RD_ACK && r_ff.idx == 2'h3);
   cov_status_read: cover property (
      r_ff.state == pmon_pkg::ST_RD_BYTE && mode == pmon_pkg::RM_STATUS);
   cov_ext_write: cover property (clr_pulse);
   cov_alert: cover property ($fell(ALERT_OUTPUT_N_OE_N));
endmodule

// ===== testbench/pmon_bus_master.sv
`timescale 1ns/10ps
module pmon_bus_master (
   input  wire logic clk,           // Core clock
   input  wire logic sda,           // Resolved data level
   output logic      scl = 1'b1,    // Bus clock, idle high
   output logic      sda_drv = 1'b1 // Data drive, high releases
);
   task automatic frame(input int n, input logic [35:0] d,
                        output logic [35:0] q);
      repeat (8) @(posedge clk);
      sda_drv <= 1'b0;
      repeat (8) @(posedge clk);
      scl <= 1'b0;
      for (int i = 35; i > 35 - 9 * n; i--) begin
         repeat (4) @(posedge clk);
         sda_drv <= d[i];
         repeat (4) @(posedge clk);
         scl <= 1'b1;
         repeat (8) @(posedge clk);
         q[i] = sda;
         scl <= 1'b0;
      end
      repeat (4) @(posedge clk);
      sda_drv <= 1'b0;
      repeat (4) @(posedge clk);
      scl <= 1'b1;
      repeat (8) @(posedge clk);
      sda_drv <= 1'b1;
   endtask
endmodule

// ===== testbench/power_monitor_i2c_readback_bench.sv
`timescale 1ns/10ps
module power_monitor_i2c_readback_bench;
   localparam logic [6:0] dev_addr = pmon_pkg::DEV_ADDR_DEFAULT;
   logic        clk = 1'b0, rst_n = 1'b0, pwr_en = 1'b1;
   logic        hs_fail = 1'b0;
   logic [1:0]  cont;
   logic [25:0] adc = 26'h0000000;
   logic        scl, sda_drv, sda_oe_n, sda_out, al_oe_n, al_out, hs_off;
   wire         sda = sda_drv & (sda_oe_n | sda_out);
   int          errors = 0, checks = 0;
   power_monitor_i2c_readback DUT (
      .CORE_CLK(clk), .RESET_N(rst_n), .SCL(scl), .SDA_IN(sda),
      .SDA_OUT(sda_out), .SDA_OE_N(sda_oe_n), .POWER_ENABLE(pwr_en),
      .V_DONE(adc[25]), .V_CODE(adc[23:12]), .I_DONE(adc[24]),
      .I_CODE(adc[11:0]), .HS_FAIL(hs_fail), .HS_OC(1'b1), .VOLT_CONT(cont[1]),
      .HOT_SWAP_OFF(hs_off), .VOLT_ONCE(), .CURR_CONT(cont[0]), .CURR_ONCE(),
      .VOLTAGE_DIVIDER_SELECT(), .ALERT_OUTPUT_N_IN(al_oe_n | al_out),
      .ALERT_OUTPUT_N_OUT(al_out), .ALERT_OUTPUT_N_OE_N(al_oe_n));
   pmon_bus_master m (.clk(clk), .sda(sda), .scl(scl), .sda_drv(sda_drv));
   initial forever #10 clk = ~clk;
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      checks++;
      if (seen !== exp) begin
         errors++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic conclude();
      if (errors == 0 && checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic wr(input logic [7:0] b1, input logic [7:0] b2);
      logic [35:0] q;
      m.frame(3, {dev_addr, 2'h1, b1, 1'b1, b2, 1'b1, 9'h000}, q);
      check({5'h00, q[27], q[18], q[9]}, 8'h00);
   endtask
   task automatic rd(input int n, input logic [23:0] e);
      logic [35:0] q;
      m.frame(n + 1, {dev_addr, 2'h3, 8'hff, 1'b0, 8'hff, (n == 2),
                      9'h1ff}, q);
      check({7'h00, q[27]}, 8'h00);
      for (int i = 0; i < n; i++)
         check(q[26 - 9 * i -: 8], e[23 - 8 * i -: 8]);
   endtask
   task automatic conv(input logic [11:0] i);
      adc <= {2'h3, 12'habc, i};
      @(posedge clk);
      adc[25:24] <= 2'h0;
      @(posedge clk);
   endtask
   task automatic fmt(input logic [7:0] c, input int n, input logic [23:0] e);
      wr(c, 8'h00);
      check({6'h00, cont}, {6'h00, c[0], c[2]});
      conv(12'hff3);
      rd(n, e);
   endtask
   initial begin
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      wr(8'h81, 8'h05);
      fmt(8'h05, 3, 24'habffc3);
      fmt(8'h01, 2, 24'habc000);
      fmt(8'h04, 2, 24'hff3000);
      fmt(8'h40, 1, 24'h040000);
      wr(8'h82, 8'h10);
      repeat (3) conv(12'h110);
      rd(1, 24'h070000);
      check({7'h00, al_oe_n}, 8'h00);
      conv(12'h100);
      hs_fail <= 1'b1;
      @(posedge clk);
      hs_fail <= 1'b0;
      rd(1, 24'h0e0000);
      wr(8'h81, 8'h1c);
      rd(1, 24'h040000);
      check({7'h00, al_oe_n}, 8'h01);
      wr(8'h83, 8'h01);
      rd(1, 24'h340000);
      check({7'h00, hs_off}, 8'h01);
      pwr_en <= 1'b0;
      wr(8'h83, 8'h00);
      check({7'h00, hs_off}, 8'h01);
      rd(1, 24'h340000);
      conclude();
   end
   initial begin
      #500000 errors++;
      conclude();
   end
endmodule
